// ### logic/cmm_core_map.sv
// Overview of operation
// - one 64K byte space reached by a 16-bit address
// - four regions: program ROM, data RAM, two special-function areas
// - ROM ends at top, starts C000, A000 or 8000 by size
// - FFE0 to top holds 16 two-byte entries: 15 interrupt, reset at FFFE
// - FFC0 to FFDF holds 16 vector-call targets, fetched by index
// - page-call targets lie in page FF00, usable up to FFBF
// - jump targets wrap flat, no page or bank boundary
// - short relative jump adds 5-bit displacement to pc, if condition
// - relative jump sign-extends 8-bit displacement before adding
// - absolute jump loads the 16-bit operand unconditionally
// - data reads reach ROM; pc plus accumulator addressing mode
// - after reset pc loads from FFFF (high) and FFFE (low)
// - pc reads as executing instruction address plus 2
// - 1K data RAM decoded at 0040 through 043F
// - short direct mode reaches 0000 to 00FF by low byte
// - 16 banks of eight bytes at 0040..00BF share RAM storage
// - RAM read of 0040 returns bank 0 accumulator
// - eight byte registers, four pairs; accumulator pair high is extension
// - pointer, pointer+disp, pointer+offset, post-increment, pre-decrement
// - fetch from data memory raises trap and drives reset pin low
// - 4-bit bank selector picks current bank, cleared by reset
// - bank selector in low nibble of status word at 003F
`timescale 1ns/100ps
`include "cmm_core_map.svh"
module cmm_core_map (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire cmm_pkg::cmm_rom_size_t rom_size_in,
  input wire cmm_pkg::cmm_pc_cmd_t pc_cmd_in,
  input wire logic cond_in,
  input wire logic [15:0] operand_in,
  input wire logic [3:0] flags_in,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire cmm_pkg::cmm_mem_mode_t mem_mode_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic [7:0] mem_wdata_in,
  input wire logic reg_req_in,
  input wire logic reg_we_in,
  input wire logic reg_pair_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [7:0] rom_data_in,
  input wire logic [7:0] io_rdata_in,
  output logic [15:0] pc_out,
  output logic busy_out,
  output logic [7:0] instr_data_out,
  output logic instr_valid_out,
  output logic [7:0] mem_rdata_out,
  output logic mem_ack_out,
  output cmm_pkg::cmm_region_t mem_region_out,
  output logic [15:0] reg_rdata_out,
  output logic reg_ack_out,
  output logic [3:0] bank_out,
  output logic [15:0] rom_addr_out,
  output logic io_req_out,
  output logic io_we_out,
  output logic [15:0] io_addr_out,
  output logic [7:0] io_wdata_out,
  output logic trap_reset_n_out
);
  import cmm_pkg::*;

  localparam int TRAP_CYC = `CMM_TRAP_CYC;

  logic [7:0] ram [0:1023];
  cmm_state_t state_q;
  cmm_state_t state_d;
  logic [15:0] pc_q;
  logic [7:0] vec_lo_q;
  logic [3:0] bank_q;
  logic fetch_pend_q;
  logic [7:0] trap_cnt_q;
  logic [15:0] acc_addr_q;
  cmm_region_t acc_region_q;
  logic [9:0] bidx;
  logic [7:0] acc_a;
  logic [15:0] hl;
  logic [15:0] eff;
  logic [15:0] hl_new;
  logic hl_upd;
  cmm_region_t eff_region;
  logic mem_take;
  logic reg_take;
  logic run_cmd;
  logic fetch_trap;
  logic [9:0] reg_idx;
  logic [7:0] rd_byte;

  function automatic logic [15:0] rom_base(input cmm_rom_size_t s);
    case (s)
      RS_16K: rom_base = `CMM_ROM16_BASE;
      RS_24K: rom_base = `CMM_ROM24_BASE;
      default: rom_base = `CMM_ROM32_BASE;
    endcase
  endfunction : rom_base

  // unmapped holes answer as RG_NONE and read back zero
  function automatic cmm_region_t region_of(input logic [15:0] a,
                                            input cmm_rom_size_t s);
    if (a >= rom_base(s)) begin
      region_of = RG_ROM;
    end else if (a >= `CMM_RAM_BASE && a <= `CMM_RAM_END) begin
      region_of = RG_RAM;
    end else if (a <= `CMM_SFR_END) begin
      region_of = RG_SFR;
    end else if (a >= `CMM_DBR_BASE && a <= `CMM_DBR_END) begin
      region_of = RG_DBR;
    end else begin
      region_of = RG_NONE;
    end
  endfunction : region_of

  function automatic logic [9:0] ram_idx(input logic [15:0] a);
    logic [15:0] off;
    off = a - `CMM_RAM_BASE;
    ram_idx = off[9:0];
  endfunction : ram_idx

  // current bank base in RAM; bank 0 byte 0 is address 0040
  assign bidx = {3'h0, bank_q, 3'h0};
  assign acc_a = ram[bidx | {7'h00, `CMM_IDX_A}];
  assign hl = {ram[bidx | {7'h00, `CMM_IDX_H}],
               ram[bidx | {7'h00, `CMM_IDX_L}]};

  assign mem_take = (state_q == ST_RUN) && mem_req_in;
  assign reg_take = (state_q == ST_RUN) && reg_req_in;
  assign run_cmd = (state_q == ST_RUN) && !mem_req_in;
  assign fetch_trap = run_cmd && (pc_cmd_in == PC_STEP) &&
                      (region_of(pc_q, rom_size_in) == RG_RAM);

  always_comb begin
    eff = mem_addr_in;
    hl_new = hl;
    hl_upd = 1'b0;
    case (mem_mode_in)
      MM_DIRECT: eff = mem_addr_in;
      MM_SHORT: eff = {`CMM_SHORT_PAGE, mem_addr_in[7:0]};
      MM_PC_ACC: eff = pc_q + {8'h00, acc_a};
      MM_PTR: eff = hl;
      MM_PTR_DISP: eff = hl + {{8{mem_addr_in[7]}}, mem_addr_in[7:0]};
      MM_PTR_OFS: eff = hl + {8'h00, ram[bidx | {7'h00, `CMM_IDX_C}]};
      MM_PTR_POSTINC: begin
        eff = hl;
        hl_new = hl + 16'h0001;
        hl_upd = 1'b1;
      end
      default: begin
        eff = hl - 16'h0001;
        hl_new = hl - 16'h0001;
        hl_upd = 1'b1;
      end
    endcase
  end

  assign eff_region = region_of(eff, rom_size_in);
  assign reg_idx = bidx | {7'h00, reg_pair_in ? {reg_sel_in[1:0], 1'b0} : reg_sel_in};

  // a register and the RAM byte at its address are one storage cell
  always_ff @(posedge core_clk_in) begin
    if (reg_take && reg_we_in) begin
      ram[reg_idx] <= reg_wdata_in[7:0];
      if (reg_pair_in) begin
        ram[reg_idx + 10'h001] <= reg_wdata_in[15:8];
      end
    end
    if (mem_take && hl_upd) begin
      ram[bidx | {7'h00, `CMM_IDX_L}] <= hl_new[7:0];
      ram[bidx | {7'h00, `CMM_IDX_H}] <= hl_new[15:8];
    end
    // data write goes last so it wins a clash with the pointer update
    if (mem_take && mem_we_in && eff_region == RG_RAM) begin
      ram[ram_idx(eff)] <= mem_wdata_in;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_VEC_LO: state_d = ST_VEC_HI;
      ST_VEC_HI: state_d = ST_RUN;
      ST_RUN: begin
        if (mem_req_in) begin
          state_d = ST_ACC;
        end else if (fetch_trap) begin
          state_d = ST_TRAP;
        end else if (pc_cmd_in == PC_VECTOR_CALL || pc_cmd_in == PC_RELOAD) begin
          state_d = ST_VCALL_LO;
        end
      end
      ST_ACC: state_d = ST_RUN;
      ST_VCALL_LO: state_d = ST_VCALL_HI;
      ST_VCALL_HI: state_d = ST_RUN;
      ST_TRAP: begin
        if (trap_cnt_q == 8'(TRAP_CYC - 1)) begin
          state_d = ST_VEC_LO;
        end
      end
      default: state_d = ST_VEC_LO;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= ST_VEC_LO;
      busy_out <= 1'b1;
    end else begin
      state_q <= state_d;
      busy_out <= (state_d != ST_RUN);
    end
  end

  // program counter; the sequencer steps it once per byte fetched,
  // so during execution it stands two bytes ahead of the opcode
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pc_q <= 16'h0000;
      vec_lo_q <= 8'h00;
    end else begin
      case (state_q)
        ST_VEC_LO, ST_VCALL_LO: vec_lo_q <= rom_data_in;
        ST_VEC_HI, ST_VCALL_HI: pc_q <= {rom_data_in, vec_lo_q};
        ST_RUN: begin
          if (run_cmd) begin
            case (pc_cmd_in)
              PC_STEP: pc_q <= pc_q + 16'h0001;
              PC_SHORT_REL: begin
                if (cond_in) begin
                  pc_q <= pc_q + {{11{operand_in[4]}}, operand_in[4:0]};
                end
              end
              PC_REL: begin
                if (cond_in) begin
                  pc_q <= pc_q + {{8{operand_in[7]}}, operand_in[7:0]};
                end
              end
              PC_ABS: pc_q <= operand_in;
              PC_PAGE_CALL: pc_q <= {`CMM_PAGE_BASE, operand_in[7:0]};
              default: pc_q <= pc_q;
            endcase
          end
        end
        default: pc_q <= pc_q;
      endcase
    end
  end

  assign pc_out = pc_q;

  // rom port is shared by fetch, vector loads and data reads
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rom_addr_out <= `CMM_RST_VEC_LO;
    end else begin
      case (state_q)
        ST_VEC_LO: rom_addr_out <= `CMM_RST_VEC_HI;
        ST_VCALL_LO: rom_addr_out <= rom_addr_out + 16'h0001;
        ST_TRAP: rom_addr_out <= `CMM_RST_VEC_LO;
        ST_RUN: begin
          if (mem_take) begin
            rom_addr_out <= eff;
          end else if (pc_cmd_in == PC_STEP) begin
            rom_addr_out <= pc_q;
          end else if (pc_cmd_in == PC_VECTOR_CALL) begin
            rom_addr_out <= `CMM_VCALL_BASE + {11'h000, operand_in[3:0], 1'b0};
          end else if (pc_cmd_in == PC_RELOAD) begin
            rom_addr_out <= `CMM_INT_VEC_BASE + {11'h000, operand_in[3:0], 1'b0};
          end
        end
        default: rom_addr_out <= rom_addr_out;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fetch_pend_q <= 1'b0;
      instr_valid_out <= 1'b0;
      instr_data_out <= 8'h00;
    end else begin
      fetch_pend_q <= run_cmd && (pc_cmd_in == PC_STEP) && !fetch_trap;
      instr_valid_out <= fetch_pend_q;
      if (fetch_pend_q) begin
        instr_data_out <= rom_data_in;
      end
    end
  end

  // trap holds the reset pin low for a fixed time, then reloads the vector
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      trap_cnt_q <= 8'h00;
      trap_reset_n_out <= 1'b1;
    end else begin
      trap_reset_n_out <= (state_d != ST_TRAP);
      if (state_q == ST_TRAP) begin
        trap_cnt_q <= trap_cnt_q + 8'h01;
      end else begin
        trap_cnt_q <= 8'h00;
      end
    end
  end

  // status word: flags are read-only, a write changes only the selector
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      bank_q <= 4'h0;
    end else if (mem_take && mem_we_in && eff == `CMM_STATUS_ADDR) begin
      bank_q <= mem_wdata_in[3:0];
    end
  end

  assign bank_out = bank_q;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      io_req_out <= 1'b0;
      io_we_out <= 1'b0;
      io_addr_out <= 16'h0000;
      io_wdata_out <= 8'h00;
    end else begin
      io_req_out <= mem_take && eff != `CMM_STATUS_ADDR &&
                    (eff_region == RG_SFR || eff_region == RG_DBR);
      if (mem_take) begin
        io_we_out <= mem_we_in;
        io_addr_out <= eff;
        io_wdata_out <= mem_wdata_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      acc_addr_q <= 16'h0000;
      acc_region_q <= RG_NONE;
    end else if (mem_take) begin
      acc_addr_q <= eff;
      acc_region_q <= eff_region;
    end
  end

  always_comb begin
    case (acc_region_q)
      RG_RAM: rd_byte = ram[ram_idx(acc_addr_q)];
      RG_ROM: rd_byte = rom_data_in;
      RG_SFR: rd_byte = (acc_addr_q == `CMM_STATUS_ADDR) ?
                        {flags_in, bank_q} : io_rdata_in;
      RG_DBR: rd_byte = io_rdata_in;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= 8'h00;
      mem_region_out <= RG_NONE;
    end else begin
      mem_ack_out <= (state_q == ST_ACC);
      if (state_q == ST_ACC) begin
        mem_rdata_out <= rd_byte;
        mem_region_out <= acc_region_q;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_ack_out <= 1'b0;
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_ack_out <= reg_take;
      if (reg_take) begin
        reg_rdata_out <= reg_pair_in ?
                         {ram[reg_idx + 10'h001], ram[reg_idx]} :
                         {8'h00, ram[reg_idx]};
      end
    end
  end
endmodule : cmm_core_map

// ### logic/cmm_core_map.svh
`ifndef CMM_CORE_MAP_SVH
`define CMM_CORE_MAP_SVH
`define CMM_ROM16_BASE 16'hC000
`define CMM_ROM24_BASE 16'hA000
`define CMM_ROM32_BASE 16'h8000
`define CMM_INT_VEC_BASE 16'hFFE0
`define CMM_VCALL_BASE 16'hFFC0
`define CMM_VCALL_END 16'hFFDF
`define CMM_PAGE_BASE 8'hFF
`define CMM_PAGE_END 16'hFFBF
`define CMM_RST_VEC_LO 16'hFFFE
`define CMM_RST_VEC_HI 16'hFFFF
`define CMM_RAM_BASE 16'h0040
`define CMM_RAM_END 16'h043F
`define CMM_SHORT_PAGE 8'h00
`define CMM_BANK_END 16'h00BF
`define CMM_STATUS_ADDR 16'h003F
`define CMM_SFR_END 16'h003F
`define CMM_DBR_BASE 16'h0F80
`define CMM_DBR_END 16'h0FFF
`define CMM_IDX_A 3'h0
`define CMM_IDX_C 3'h2
`define CMM_IDX_L 3'h6
`define CMM_IDX_H 3'h7
`define CMM_PC_AHEAD 16'h0002
`define CMM_CLK_NS 4
`define CMM_TRAP_NS 64
`define CMM_TRAP_CYC ((`CMM_TRAP_NS + `CMM_CLK_NS - 1) / `CMM_CLK_NS)
`endif

// ### logic/cmm_pkg.sv
package cmm_pkg;
  typedef enum logic [3:0] {
    PC_NONE = 4'h0,
    PC_STEP = 4'h1,
    PC_SHORT_REL = 4'h2,
    PC_REL = 4'h3,
    PC_ABS = 4'h4,
    PC_VECTOR_CALL = 4'h5,
    PC_PAGE_CALL = 4'h6,
    PC_RELOAD = 4'h7
  } cmm_pc_cmd_t;
  typedef enum logic [2:0] {
    MM_DIRECT = 3'h0,
    MM_SHORT = 3'h1,
    MM_PC_ACC = 3'h2,
    MM_PTR = 3'h3,
    MM_PTR_DISP = 3'h4,
    MM_PTR_OFS = 3'h5,
    MM_PTR_POSTINC = 3'h6,
    MM_PTR_PREDEC = 3'h7
  } cmm_mem_mode_t;
  typedef enum logic [2:0] {
    RG_NONE = 3'h0,
    RG_SFR = 3'h1,
    RG_DBR = 3'h2,
    RG_RAM = 3'h3,
    RG_ROM = 3'h4
  } cmm_region_t;
  typedef enum logic [1:0] {
    RS_16K = 2'h0,
    RS_24K = 2'h1,
    RS_32K = 2'h2
  } cmm_rom_size_t;
  typedef enum logic [2:0] {
    ST_VEC_LO = 3'h0,
    ST_VEC_HI = 3'h1,
    ST_RUN = 3'h2,
    ST_ACC = 3'h3,
    ST_VCALL_LO = 3'h4,
    ST_VCALL_HI = 3'h5,
    ST_TRAP = 3'h6
  } cmm_state_t;
endpackage : cmm_pkg

// ### testbench/cmm_core_map_props.sv
`timescale 1ns/100ps
module cmm_core_map_props (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire cmm_pkg::cmm_pc_cmd_t pc_cmd_in,
  input wire logic cond_in,
  input wire logic [15:0] operand_in,
  input wire logic mem_req_in,
  input wire cmm_pkg::cmm_mem_mode_t mem_mode_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic reg_req_in,
  input wire logic [7:0] rom_data_in,
  input wire logic [15:0] pc_out,
  input wire logic busy_out,
  input wire logic mem_ack_out,
  input wire cmm_pkg::cmm_region_t mem_region_out,
  input wire logic reg_ack_out,
  input wire logic [3:0] bank_out,
  input wire logic [15:0] rom_addr_out,
  input wire logic io_req_out,
  input wire logic [15:0] io_addr_out,
  input wire logic trap_reset_n_out
);
  import cmm_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  logic [4:0] low_q;
  logic [4:0] low_d;
  logic pc_go;
  logic dir_go;
  logic in_ram;
  logic [15:0] rel8;
  logic [15:0] rel5;
  assign pc_go = !busy_out && !mem_req_in;
  assign dir_go = mem_req_in && !busy_out && mem_mode_in == MM_DIRECT;
  assign in_ram = pc_out >= 16'h0040 && pc_out <= 16'h043F;
  assign rel8 = cond_in ? {{8{operand_in[7]}}, operand_in[7:0]} : 16'h0000;
  assign rel5 = cond_in ? {{11{operand_in[4]}}, operand_in[4:0]} : 16'h0000;
  assign low_d = trap_reset_n_out ? 5'h00 : low_q + 5'h01;
  // counter instead of a 16-long repetition, which tools unroll badly
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      low_q <= 5'h00;
    end else begin
      low_q <= low_d;
    end
  end
  AST_RESET_VEC: assert property ($fell(reset_in) |-> bank_out == 4'h0 &&
    trap_reset_n_out && rom_addr_out == 16'hFFFE ##1 rom_addr_out == 16'hFFFF
    ##1 pc_out == {$past(rom_data_in), $past(rom_data_in, 2)} && !busy_out)
    else $error("reset vector load wrong");
  AST_MEM_ACK: assert property (mem_req_in && !busy_out |=> !mem_ack_out ##1 mem_ack_out)
    else $error("memory ack timing wrong");
  AST_REG_ACK: assert property (reg_req_in && !busy_out |=> reg_ack_out)
    else $error("register ack missing");
  AST_PC_STEP: assert property (pc_go && pc_cmd_in == PC_STEP && !in_ram |=>
    pc_out == $past(pc_out) + 16'h0001) else $error("step did not advance pc");
  AST_REL: assert property (pc_go && pc_cmd_in == PC_REL |=> pc_out == $past(pc_out) + $past(rel8))
    else $error("relative jump target wrong");
  AST_SHORT_REL: assert property (pc_go && pc_cmd_in == PC_SHORT_REL |=>
    pc_out == $past(pc_out) + $past(rel5)) else $error("short jump target wrong");
  AST_ABS: assert property (pc_go && pc_cmd_in == PC_ABS |=> pc_out == $past(operand_in))
    else $error("absolute jump target wrong");
  AST_TRAP_ENTER: assert property (pc_go && pc_cmd_in == PC_STEP && in_ram |=>
    !trap_reset_n_out) else $error("fetch from ram not trapped");
  AST_TRAP_LEN: assert property ($rose(trap_reset_n_out) |-> low_q == 5'h10)
    else $error("trap pulse length wrong");
  AST_RAM_REGION: assert property (dir_go && mem_addr_in >= 16'h0040 &&
    mem_addr_in <= 16'h043F |-> ##2 mem_region_out == RG_RAM) else $error("ram not decoded");
  AST_IO_REQ: assert property (dir_go && mem_addr_in < 16'h003F |=>
    io_req_out && io_addr_out == $past(mem_addr_in)) else $error("sfr access not passed on");
  cover property (pc_go && pc_cmd_in == PC_VECTOR_CALL);
  cover property ($rose(trap_reset_n_out));
  cover property (mem_ack_out && mem_region_out == RG_ROM);
endmodule : cmm_core_map_props

bind cmm_core_map cmm_core_map_props i_props (.*);

// ### testbench/cmm_rom_model.sv
`timescale 1ns/100ps
module cmm_rom_model (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [15:0] rom_addr_in,
  input wire logic io_req_in,
  input wire logic [15:0] io_addr_in,
  output logic [7:0] rom_data_out,
  output logic [7:0] io_rdata_out
);
  logic [7:0] idle_q;
  // vector C03E at the top, other bytes derived from the address
  function automatic logic [7:0] rom_byte(input logic [15:0] a);
    if (a == 16'hFFFE) begin
      return 8'h3E;
    end
    if (a == 16'hFFFF) begin
      return 8'hC0;
    end
    return a[7:0] + a[15:8];
  endfunction : rom_byte
  assign rom_data_out = rom_byte(rom_addr_in);
  // a released bus toggles so a stale byte never passes for data
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      idle_q <= 8'h00;
    end else begin
      idle_q <= ~idle_q;
    end
  end
  assign io_rdata_out = io_req_in ? ~io_addr_in[7:0] : idle_q;
endmodule : cmm_rom_model

// ### testbench/cmm_core_map_tb_top.sv
`timescale 1ns/100ps
module cmm_core_map_tb_top;
  import cmm_pkg::*;
  typedef struct packed {
    logic m;
    logic we;
    logic [3:0] c;
    logic cd;
    logic [15:0] v;
    logic [7:0] wd;
    logic [15:0] e;
    cmm_region_t rg;
  } cmm_row_t;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  cmm_rom_size_t rom_size_in = RS_16K;
  cmm_pc_cmd_t pc_cmd_in = PC_NONE;
  logic cond_in = 1'b0;
  logic [15:0] operand_in = 16'h0000;
  logic [3:0] flags_in = 4'hA;
  logic mem_req_in = 1'b0;
  logic mem_we_in = 1'b0;
  cmm_mem_mode_t mem_mode_in = MM_DIRECT;
  logic [15:0] mem_addr_in = 16'h0000;
  logic [7:0] mem_wdata_in = 8'h00;
  logic reg_req_in = 1'b0;
  logic reg_we_in = 1'b0;
  logic reg_pair_in = 1'b0;
  logic [2:0] reg_sel_in = 3'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [7:0] rom_data_in;
  logic [7:0] io_rdata_in;
  logic [15:0] pc_out;
  logic busy_out;
  logic [7:0] instr_data_out;
  logic instr_valid_out;
  logic [7:0] mem_rdata_out;
  logic mem_ack_out;
  cmm_region_t mem_region_out;
  logic [15:0] reg_rdata_out;
  logic reg_ack_out;
  logic [3:0] bank_out;
  logic [15:0] rom_addr_out;
  logic io_req_out;
  logic io_we_out;
  logic [15:0] io_addr_out;
  logic [7:0] io_wdata_out;
  logic trap_reset_n_out;
  int errors = 0;
  int n_tests = 0;
  cmm_row_t r;
  logic [15:0] bases [3] = '{16'hC000, 16'hA000, 16'h8000};
  cmm_row_t rows [15] = '{
    '{1'b0, 1'b0, 4'h4, 1'b0, 16'hE8C6, 8'h00, 16'hE8C6, RG_NONE},
    '{1'b0, 1'b0, 4'h2, 1'b1, 16'h0008, 8'h00, 16'hE8CE, RG_NONE},
    '{1'b0, 1'b0, 4'h3, 1'b1, 16'h0080, 8'h00, 16'hE84E, RG_NONE},
    '{1'b0, 1'b0, 4'h3, 1'b0, 16'h0010, 8'h00, 16'hE84E, RG_NONE},
    '{1'b0, 1'b0, 4'h2, 1'b1, 16'h001F, 8'h00, 16'hE84D, RG_NONE},
    '{1'b0, 1'b0, 4'h2, 1'b0, 16'h0008, 8'h00, 16'hE84D, RG_NONE},
    '{1'b0, 1'b0, 4'h4, 1'b0, 16'hFFFF, 8'h00, 16'hFFFF, RG_NONE},
    '{1'b0, 1'b0, 4'h1, 1'b0, 16'h0000, 8'h00, 16'h0000, RG_NONE},
    '{1'b1, 1'b1, 4'h0, 1'b0, 16'h0100, 8'h55, 16'h0000, RG_RAM},
    '{1'b1, 1'b0, 4'h0, 1'b0, 16'h0100, 8'h00, 16'h0055, RG_RAM},
    '{1'b1, 1'b0, 4'h0, 1'b0, 16'h0440, 8'h00, 16'h0000, RG_NONE},
    '{1'b1, 1'b0, 4'h0, 1'b0, 16'h0010, 8'h00, 16'h00EF, RG_SFR},
    '{1'b1, 1'b0, 4'h0, 1'b0, 16'h0F80, 8'h00, 16'h007F, RG_DBR},
    '{1'b1, 1'b1, 4'h0, 1'b0, 16'h003F, 8'h05, 16'h0000, RG_SFR},
    '{1'b1, 1'b0, 4'h0, 1'b0, 16'h003F, 8'h00, 16'h00A5, RG_SFR}};
  cmm_core_map i_dut (.*);
  cmm_rom_model i_rom (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .rom_addr_in(rom_addr_out), .io_req_in(io_req_out), .io_addr_in(io_addr_out),
    .rom_data_out(rom_data_in), .io_rdata_out(io_rdata_in));
  always #2 core_clk_in = ~core_clk_in;
  task automatic tick();
    @(posedge core_clk_in);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic wait_idle();
    for (int i = 0; i < 40 && busy_out !== 1'b0; i++) begin
      tick();
    end
    chk({15'h0000, busy_out}, 16'h0000, "idle");
    if (busy_out !== 1'b0) begin
      results();
    end
  endtask : wait_idle
  task automatic mem(input logic we, input cmm_mem_mode_t md, input logic [15:0] a,
                     input logic [7:0] wd);
    mem_req_in = 1'b1;
    mem_we_in = we;
    mem_mode_in = md;
    mem_addr_in = a;
    mem_wdata_in = wd;
    tick();
    mem_req_in = 1'b0;
    for (int i = 0; i < 8 && mem_ack_out !== 1'b1; i++) begin
      tick();
    end
    chk({15'h0000, mem_ack_out}, 16'h0001, "mem ack");
    if (mem_ack_out !== 1'b1) begin
      results();
    end
  endtask : mem
  task automatic rg(input logic we, input logic pr, input logic [2:0] s, input logic [15:0] wd);
    reg_req_in = 1'b1;
    reg_we_in = we;
    reg_pair_in = pr;
    reg_sel_in = s;
    reg_wdata_in = wd;
    tick();
    reg_req_in = 1'b0;
    chk({15'h0000, reg_ack_out}, 16'h0001, "reg ack");
  endtask : rg
  task automatic pc_do(input cmm_pc_cmd_t c, input logic cd, input logic [15:0] op);
    pc_cmd_in = c;
    cond_in = cd;
    operand_in = op;
    tick();
    pc_cmd_in = PC_NONE;
    // one idle edge so back-to-back commands never retarget the same step
    tick();
  endtask : pc_do
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (10) tick();
    reset_in = 1'b0;
    wait_idle();
    chk(pc_out, 16'hC03E, "reset pc");
    chk({12'h000, bank_out}, 16'h0000, "reset bank");
    $display("reset done");
  endtask : do_reset
  initial begin
    do_reset();
    foreach (rows[i]) begin
      r = rows[i];
      if (r.m) begin
        mem(r.we, cmm_mem_mode_t'(r.c[2:0]), r.v, r.wd);
        chk({13'h0000, mem_region_out}, {13'h0000, r.rg}, "region");
        if (!r.we) begin
          chk({8'h00, mem_rdata_out}, r.e, "rdata");
        end
      end else begin
        pc_do(cmm_pc_cmd_t'(r.c), r.cd, r.v);
        chk(pc_out, r.e, "pc");
        if (r.c == 4'h1) begin
          chk({15'h0000, instr_valid_out}, 16'h0001, "fetch");
          chk({8'h00, instr_data_out}, {8'h00, i_rom.rom_byte(16'hFFFF)}, "byte");
        end
      end
      $display("row %0d done", i);
    end
    chk({12'h000, bank_out}, 16'h0005, "bank");
    rg(1'b1, 1'b0, 3'h0, 16'h009C);
    mem(1'b0, MM_DIRECT, 16'h0068, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h009C, "alias");
    mem(1'b1, MM_DIRECT, 16'h0069, 8'h12);
    rg(1'b0, 1'b1, 3'h0, 16'h0000);
    chk(reg_rdata_out, 16'h129C, "pair");
    mem(1'b0, MM_SHORT, 16'hAB69, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h0012, "short");
    rg(1'b1, 1'b1, 3'h3, 16'h0100);
    mem(1'b0, MM_PTR_POSTINC, 16'h0000, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h0055, "post inc");
    rg(1'b0, 1'b1, 3'h3, 16'h0000);
    chk(reg_rdata_out, 16'h0101, "pointer");
    mem(1'b0, MM_PTR_PREDEC, 16'h0000, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h0055, "pre dec");
    mem(1'b1, MM_DIRECT, 16'h00FF, 8'h3C);
    mem(1'b0, MM_PTR_DISP, 16'h00FF, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h003C, "disp");
    mem(1'b0, MM_PTR, 16'h0000, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h0055, "ptr");
    mem(1'b1, MM_DIRECT, 16'h01FF, 8'hA7);
    rg(1'b1, 1'b0, 3'h2, 16'h00FF);
    mem(1'b0, MM_PTR_OFS, 16'h0000, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h00A7, "ptr ofs");
    mem(1'b1, MM_DIRECT, 16'h0020, 8'h5A);
    chk({7'h00, io_we_out, io_wdata_out}, 16'h015A, "io write");
    pc_do(PC_ABS, 1'b0, 16'hC000);
    mem(1'b0, MM_PC_ACC, 16'h0000, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h005C, "pc plus acc");
    for (int s = 0; s < 3; s++) begin
      rom_size_in = cmm_rom_size_t'(s);
      mem(1'b0, MM_DIRECT, bases[s], 8'h00);
      chk({13'h0000, mem_region_out}, {13'h0000, RG_ROM}, "rom");
      mem(1'b0, MM_DIRECT, bases[s] - 16'h0001, 8'h00);
      chk({13'h0000, mem_region_out}, {13'h0000, RG_NONE}, "below rom");
    end
    rom_size_in = RS_16K;
    pc_do(PC_VECTOR_CALL, 1'b0, 16'h000F);
    wait_idle();
    chk(pc_out, 16'hDEDD, "vector call");
    pc_do(PC_RELOAD, 1'b0, 16'h0000);
    wait_idle();
    chk(pc_out, 16'hE0DF, "int vector");
    pc_do(PC_PAGE_CALL, 1'b0, 16'h0012);
    wait_idle();
    chk(pc_out, 16'hFF12, "page call");
    $display("calls done");
    pc_do(PC_ABS, 1'b0, 16'h0100);
    pc_do(PC_STEP, 1'b0, 16'h0000);
    chk({15'h0000, trap_reset_n_out}, 16'h0000, "trap");
    wait_idle();
    chk(pc_out, 16'hC03E, "after trap");
    $display("trap done");
    do_reset();
    rg(1'b1, 1'b0, 3'h0, 16'h0077);
    mem(1'b0, MM_DIRECT, 16'h0040, 8'h00);
    chk({8'h00, mem_rdata_out}, 16'h0077, "bank0 acc");
    results();
  end
endmodule : cmm_core_map_tb_top
